/* File: design/cbsu_defs.vh */
`ifndef CBSU_DEFS_VH
`define CBSU_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses on the register bus)
// ****************************************************************
`define CBSU_OFF_OP 8'h00
`define CBSU_OFF_OPND 8'h04
`define CBSU_OFF_PC 8'h08
`define CBSU_OFF_FLAGS 8'h0c
`define CBSU_OFF_IOVAL 8'h10
`define CBSU_OFF_NEXTW 8'h14
`define CBSU_OFF_STACK 8'h18
`define CBSU_OFF_RESULT 8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define CBSU_OPND_A_LSB 0
`define CBSU_OPND_B_LSB 8
`define CBSU_OPND_BIT_LSB 16
`define CBSU_OPND_K_LSB 24
`define CBSU_RES_BUSY 16
`define CBSU_RES_SKIP 17
`define CBSU_RES_TAKEN 18
`define CBSU_RES_CYC_LSB 20

// Status flag bit positions.
`define CBSU_FLAG_C 0
`define CBSU_FLAG_Z 1
`define CBSU_FLAG_N 2
`define CBSU_FLAG_V 3
`define CBSU_FLAG_S 4
`define CBSU_FLAG_H 5
`define CBSU_FLAG_T 6
`define CBSU_FLAG_I 7

// ****************************************************************
// Operation codes
// ****************************************************************
`define CBSU_OP_COMPARE_REGS 5'h00
`define CBSU_OP_COMPARE_REGS_WITH_CARRY 5'h01
`define CBSU_OP_COMPARE_IMMEDIATE 5'h02
`define CBSU_OP_COMPARE_SKIP_EQUAL 5'h03
`define CBSU_OP_SKIP_REG_BIT_CLEAR 5'h04
`define CBSU_OP_SKIP_REG_BIT_SET 5'h05
`define CBSU_OP_SKIP_IO_BIT_CLEAR 5'h06
`define CBSU_OP_SKIP_IO_BIT_SET 5'h07
`define CBSU_OP_BRANCH_STATUS_BIT_SET 5'h08
`define CBSU_OP_BRANCH_STATUS_BIT_CLEAR 5'h09
`define CBSU_OP_BRANCH_EQUAL 5'h0a
`define CBSU_OP_BRANCH_NOT_EQUAL 5'h0b
`define CBSU_OP_BRANCH_CARRY_SET 5'h0c
`define CBSU_OP_BRANCH_CARRY_CLEAR 5'h0d
`define CBSU_OP_BRANCH_SAME_OR_HIGHER 5'h0e
`define CBSU_OP_BRANCH_LOWER 5'h0f
`define CBSU_OP_BRANCH_MINUS 5'h10
`define CBSU_OP_BRANCH_PLUS 5'h11
`define CBSU_OP_BRANCH_SIGNED_GE 5'h12
`define CBSU_OP_BRANCH_SIGNED_LT 5'h13
`define CBSU_OP_BRANCH_HALF_CARRY_SET 5'h14
`define CBSU_OP_BRANCH_HALF_CARRY_CLEAR 5'h15
`define CBSU_OP_BRANCH_TRANSFER_BIT_SET 5'h16
`define CBSU_OP_BRANCH_TRANSFER_BIT_CLEAR 5'h17
`define CBSU_OP_BRANCH_OVERFLOW_SET 5'h18
`define CBSU_OP_BRANCH_OVERFLOW_CLEAR 5'h19
`define CBSU_OP_RETURN_FROM_INTERRUPT 5'h1a

// ****************************************************************
// Cycle counts and reset values
// ****************************************************************
`define CBSU_CYC_ONE 3'h1
`define CBSU_CYC_TWO 3'h2
`define CBSU_CYC_THREE 3'h3
`define CBSU_CYC_RETURN 3'h4
`define CBSU_RST_FLAGS 8'h00
`define CBSU_RST_PC 16'h0000
`define CBSU_RESP_OKAY 2'b00
`define CBSU_RESP_SLVERR 2'b10

`endif

/* File: design/cbsu_cmp_alu.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Eight-bit subtract that only produces flags
// ****************************************************************
module cbsu_cmp_alu (
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  output wire c,
  output wire z,
  output wire n,
  output wire v,
  output wire h
);

  wire [7:0] r;

  // The difference itself is never stored; only its flags leave here.
  assign r = a - b - {7'h00, cin};
  assign h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  assign c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
  assign v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  assign n = r[7];
  assign z = (r == 8'h00);

endmodule // cbsu_cmp_alu

`default_nettype wire

/* File: design/cbsu_core.v */
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cbsu_defs.vh"

module cbsu_core (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [4:0] op_q;
  reg [31:0] opnd_q;
  reg [15:0] pc_q;
  reg [7:0] flags_q;
  reg [7:0] ioval_q;
  reg nextw_q;
  reg [15:0] stack_q;
  reg state_q;
  reg [2:0] cnt_q;
  reg [2:0] cyc_q;
  reg skip_q;
  reg taken_q;

  reg aw_got_q;
  reg w_got_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // ****************************************************************
  // Register bus, write side
  // ****************************************************************
  // Address and data are caught independently so either may come first.
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_got_q | aw_take;
  wire w_have = w_got_q | w_take;
  wire wr_en = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0] wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;

  wire wr_mapped = (wr_addr == `CBSU_OFF_OP) ||
                   (wr_addr == `CBSU_OFF_OPND) ||
                   (wr_addr == `CBSU_OFF_PC) ||
                   (wr_addr == `CBSU_OFF_FLAGS) ||
                   (wr_addr == `CBSU_OFF_IOVAL) ||
                   (wr_addr == `CBSU_OFF_NEXTW) ||
                   (wr_addr == `CBSU_OFF_STACK) ||
                   (wr_addr == `CBSU_OFF_RESULT);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // A write to the operation register starts work; refused while busy.
  wire start = wr_en & (wr_addr == `CBSU_OFF_OP) & wr_strb[0] &
               (state_q == ST_IDLE);
  wire [31:0] op_m = merge({27'h0000000, op_q}, wr_data, wr_strb);
  wire [31:0] pc_m = merge({16'h0000, pc_q}, wr_data, wr_strb);
  wire [31:0] stack_m = merge({16'h0000, stack_q}, wr_data, wr_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CBSU_RESP_OKAY;
    end else begin
      if (wr_en) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `CBSU_RESP_OKAY : `CBSU_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_got_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_got_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Compare datapath
  // ****************************************************************
  wire [7:0] val_a = opnd_q[`CBSU_OPND_A_LSB +: 8];
  wire [7:0] val_b = opnd_q[`CBSU_OPND_B_LSB +: 8];
  wire [2:0] bit_sel = opnd_q[`CBSU_OPND_BIT_LSB +: 3];
  wire [6:0] k_off = opnd_q[`CBSU_OPND_K_LSB +: 7];
  wire use_carry = (op_m[4:0] == `CBSU_OP_COMPARE_REGS_WITH_CARRY);
  wire f_c;
  wire f_z;
  wire f_n;
  wire f_v;
  wire f_h;

  cbsu_cmp_alu u_alu (
    .a(val_a),
    .b(val_b),
    .cin(use_carry & flags_q[`CBSU_FLAG_C]),
    .c(f_c),
    .z(f_z),
    .n(f_n),
    .v(f_v),
    .h(f_h)
  );

  // ****************************************************************
  // Decode and outcome
  // ****************************************************************
  // The kind of an op follows from its code range; one mux gives cond.
  wire fl_c = flags_q[`CBSU_FLAG_C];
  wire fl_z = flags_q[`CBSU_FLAG_Z];
  wire fl_n = flags_q[`CBSU_FLAG_N];
  wire fl_v = flags_q[`CBSU_FLAG_V];
  wire fl_h = flags_q[`CBSU_FLAG_H];
  wire fl_t = flags_q[`CBSU_FLAG_T];
  reg is_cmp;
  reg is_skip;
  reg is_branch;
  reg is_ret;
  reg cond;

  always @* begin
    is_cmp = (op_m[4:0] <= `CBSU_OP_COMPARE_IMMEDIATE);
    is_skip = (op_m[4:0] >= `CBSU_OP_COMPARE_SKIP_EQUAL) &&
              (op_m[4:0] <= `CBSU_OP_SKIP_IO_BIT_SET);
    is_branch = (op_m[4:0] >= `CBSU_OP_BRANCH_STATUS_BIT_SET) &&
                (op_m[4:0] <= `CBSU_OP_BRANCH_OVERFLOW_CLEAR);
    is_ret = (op_m[4:0] == `CBSU_OP_RETURN_FROM_INTERRUPT);
    cond = 1'b0;
    case (op_m[4:0])
      `CBSU_OP_COMPARE_SKIP_EQUAL: cond = (val_a == val_b);
      `CBSU_OP_SKIP_REG_BIT_CLEAR: cond = ~val_a[bit_sel];
      `CBSU_OP_SKIP_REG_BIT_SET: cond = val_a[bit_sel];
      `CBSU_OP_SKIP_IO_BIT_CLEAR: cond = ~ioval_q[bit_sel];
      `CBSU_OP_SKIP_IO_BIT_SET: cond = ioval_q[bit_sel];
      `CBSU_OP_BRANCH_STATUS_BIT_SET: cond = flags_q[bit_sel];
      `CBSU_OP_BRANCH_STATUS_BIT_CLEAR: cond = ~flags_q[bit_sel];
      `CBSU_OP_BRANCH_EQUAL: cond = fl_z;
      `CBSU_OP_BRANCH_NOT_EQUAL: cond = ~fl_z;
      `CBSU_OP_BRANCH_CARRY_SET: cond = fl_c;
      `CBSU_OP_BRANCH_CARRY_CLEAR: cond = ~fl_c;
      `CBSU_OP_BRANCH_SAME_OR_HIGHER: cond = ~fl_c;
      `CBSU_OP_BRANCH_LOWER: cond = fl_c;
      `CBSU_OP_BRANCH_MINUS: cond = fl_n;
      `CBSU_OP_BRANCH_PLUS: cond = ~fl_n;
      `CBSU_OP_BRANCH_SIGNED_GE: cond = ~(fl_n ^ fl_v);
      `CBSU_OP_BRANCH_SIGNED_LT: cond = fl_n ^ fl_v;
      `CBSU_OP_BRANCH_HALF_CARRY_SET: cond = fl_h;
      `CBSU_OP_BRANCH_HALF_CARRY_CLEAR: cond = ~fl_h;
      `CBSU_OP_BRANCH_TRANSFER_BIT_SET: cond = fl_t;
      `CBSU_OP_BRANCH_TRANSFER_BIT_CLEAR: cond = ~fl_t;
      `CBSU_OP_BRANCH_OVERFLOW_SET: cond = fl_v;
      `CBSU_OP_BRANCH_OVERFLOW_CLEAR: cond = ~fl_v;
      default: cond = 1'b0;
    endcase
  end

  // Offsets are seven-bit two's complement, so the reach is -64 to +63.
  wire [15:0] k_ext = {{9{k_off[6]}}, k_off};
  reg [15:0] pc_d;
  reg [7:0] flags_d;
  reg [2:0] cyc_d;

  always @* begin
    pc_d = pc_q + 16'h0001;
    flags_d = flags_q;
    cyc_d = `CBSU_CYC_ONE;
    if (is_cmp) begin
      flags_d[`CBSU_FLAG_C] = f_c;
      flags_d[`CBSU_FLAG_Z] = f_z;
      flags_d[`CBSU_FLAG_N] = f_n;
      flags_d[`CBSU_FLAG_V] = f_v;
      flags_d[`CBSU_FLAG_H] = f_h;
    end else if (is_skip && cond) begin
      // The length of the skipped word is told by the fetch side.
      if (nextw_q) begin
        pc_d = pc_q + 16'h0003;
        cyc_d = `CBSU_CYC_THREE;
      end else begin
        pc_d = pc_q + 16'h0002;
        cyc_d = `CBSU_CYC_TWO;
      end
    end else if (is_branch && cond) begin
      pc_d = pc_q + k_ext + 16'h0001;
      cyc_d = `CBSU_CYC_TWO;
    end else if (is_ret) begin
      pc_d = stack_q;
      flags_d[`CBSU_FLAG_I] = 1'b1;
      cyc_d = `CBSU_CYC_RETURN;
    end
  end

  // ****************************************************************
  // Execution sequencing and registers
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      op_q <= 5'h00;
      opnd_q <= 32'h00000000;
      pc_q <= `CBSU_RST_PC;
      flags_q <= `CBSU_RST_FLAGS;
      ioval_q <= 8'h00;
      nextw_q <= 1'b0;
      stack_q <= 16'h0000;
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      cyc_q <= 3'h0;
      skip_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q <= op_m[4:0];
            pc_q <= pc_d;
            flags_q <= flags_d;
            cyc_q <= cyc_d;
            cnt_q <= cyc_d;
            skip_q <= is_skip & cond;
            taken_q <= is_branch & cond;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // Operand writes stay blocked while busy so the outcome is stable.
      if (wr_en && state_q == ST_IDLE) begin
        case (wr_addr)
          `CBSU_OFF_OPND: opnd_q <= merge(opnd_q, wr_data, wr_strb);
          `CBSU_OFF_PC: pc_q <= pc_m[15:0];
          `CBSU_OFF_FLAGS: flags_q <= wr_strb[0] ? wr_data[7:0] : flags_q;
          `CBSU_OFF_IOVAL: ioval_q <= wr_strb[0] ? wr_data[7:0] : ioval_q;
          `CBSU_OFF_NEXTW: nextw_q <= wr_strb[0] ? wr_data[0] : nextw_q;
          `CBSU_OFF_STACK: stack_q <= stack_m[15:0];
          default: nextw_q <= nextw_q;
        endcase
      end
    end
  end

  // ****************************************************************
  // Register bus, read side
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;
  wire busy = (state_q == ST_EXEC);
  reg [31:0] rd_d;
  reg rd_ok;

  always @* begin
    rd_d = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CBSU_OFF_OP: rd_d = {27'h0000000, op_q};
      `CBSU_OFF_OPND: rd_d = opnd_q;
      `CBSU_OFF_PC: rd_d = {16'h0000, pc_q};
      `CBSU_OFF_FLAGS: rd_d = {24'h000000, flags_q};
      `CBSU_OFF_IOVAL: rd_d = {24'h000000, ioval_q};
      `CBSU_OFF_NEXTW: rd_d = {31'h00000000, nextw_q};
      `CBSU_OFF_STACK: rd_d = {16'h0000, stack_q};
      `CBSU_OFF_RESULT: begin
        rd_d[15:0] = pc_q;
        rd_d[`CBSU_RES_BUSY] = busy;
        rd_d[`CBSU_RES_SKIP] = skip_q;
        rd_d[`CBSU_RES_TAKEN] = taken_q;
        rd_d[`CBSU_RES_CYC_LSB +: 3] = cyc_q;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CBSU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? `CBSU_RESP_OKAY : `CBSU_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // cbsu_core

`default_nettype wire

/* File: verif/cbsu_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Register bus master standing in for the fetch stage
// ****************************************************************
// Both ready lines stay high all the time, so a new request can
// follow straight after an answer without lowering any strobe.
module cbsu_host (
  input wire logic aclk,
  output logic [7:0] aw,
  output logic awv,
  input wire logic awr,
  output logic [31:0] wd,
  output logic wv,
  input wire logic wrd,
  input wire logic [1:0] br,
  input wire logic bv,
  output logic bry,
  output logic [7:0] ar,
  output logic arv,
  input wire logic arr,
  input wire logic [31:0] rd,
  input wire logic [1:0] rr,
  input wire logic rv,
  output logic rry
);
  initial begin
    {aw, awv, wd, wv} = '0;
    {ar, arv} = '0;
    bry = 1'b1;
    rry = 1'b1;
  end
  task automatic write(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    r = br;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    ar <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    r = rr;
  endtask
endmodule // cbsu_host
`default_nettype wire

/* File: verif/cbsu_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module cbsu_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  logic [7:0] ra_q;
  logic [4:0] op_q;
  logic ran_q;
  wire res_rd = s_axi_rvalid && ran_q && ra_q == 8'h1c;
  wire sk = s_axi_rdata[17];
  wire tk = s_axi_rdata[18];
  wire [2:0] cy = s_axi_rdata[22:20];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_aw_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Remembers the last op written to offset 0, busy or not, so result reads can be judged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_q <= 8'h00;
      op_q <= 5'h00;
      ran_q <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
          s_axi_wready && s_axi_awaddr == 8'h00) begin
        op_q <= s_axi_wdata[4:0];
        ran_q <= 1'b1;
      end
    end
  end
  property p_skip(logic [4:0] lo, logic [4:0] hi);
    res_rd && op_q >= lo && op_q <= hi |->
      !tk && (sk ? (cy == 3'h2 || cy == 3'h3) : cy == 3'h1);
  endproperty
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_aw_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  a_unmapped_read: assert property (s_ar_take and
    s_axi_araddr > 8'h1c |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_cmp_cycles: assert property (res_rd && op_q <= 5'h02 |->
    cy == 3'h1 && !sk && !tk) else $error("compare timing wrong");
  a_cse_cycles: assert property (p_skip(5'h03, 5'h03))
    else $error("equal skip timing wrong");
  a_regbit_cycles: assert property (p_skip(5'h04, 5'h05))
    else $error("register bit skip timing wrong");
  a_iobit_cycles: assert property (p_skip(5'h06, 5'h07))
    else $error("io bit skip timing wrong");
  a_branch_cycles: assert property (res_rd && op_q >= 5'h08 &&
    op_q <= 5'h19 |-> !sk && cy == (tk ? 3'h2 : 3'h1))
    else $error("branch timing wrong");
  a_return_cycles: assert property (res_rd && op_q == 5'h1a |->
    cy == 3'h4) else $error("return timing wrong");
endmodule // cbsu_chk
bind cbsu_core cbsu_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

/* File: verif/tb_compare_skip_branch_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cbsu_defs.vh"
// ****************************************************************
// Testbench
// ****************************************************************
module tb_compare_skip_branch_unit;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw, ar;
  logic [31:0] wd, rd, res, fw;
  logic awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
  logic [1:0] br, rr, resp;
  int failures = 0;
  int checked = 0;
  always #2.5 aclk = ~aclk;
  cbsu_core dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  cbsu_host host_u (.aclk(aclk), .aw(aw), .awv(awv), .awr(awr),
    .wd(wd), .wv(wv), .wrd(wrd), .br(br), .bv(bv), .bry(bry),
    .ar(ar), .arv(arv), .arr(arr), .rd(rd), .rr(rr), .rv(rv),
    .rry(rry));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  function automatic logic [31:0] rx(logic [2:0] c, logic t, s,
    logic [15:0] pc);
    return {9'h0, c, 1'b0, t, s, 1'b0, pc};
  endfunction
  function automatic logic [7:0] cmpf(logic [7:0] a, b, logic ci);
    logic [8:0] r;
    logic [7:0] f;
    logic [4:0] lo;
    r = {1'b0, a} - {1'b0, b} - ci;
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci;
    f = 8'h00;
    f[0] = r[8];
    f[1] = r[7:0] == 8'h00;
    f[2] = r[7];
    f[3] = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    f[5] = lo[4];
    return f;
  endfunction
  function automatic logic bcond(logic [4:0] op, logic [7:0] f,
    logic [2:0] s);
    logic v;
    case (op[4:1])
      4'h4: v = f[s];
      4'h5: v = f[1];
      4'h6: v = f[0];
      4'h7: v = ~f[0];
      4'h8: v = f[2];
      4'h9: v = ~(f[2] ^ f[3]);
      4'ha: v = f[5];
      4'hb: v = f[6];
      default: v = f[3];
    endcase
    return v ^ op[0];
  endfunction
  // Programs operands first and starts the op last; pk pokes PC
  // while busy, which must be ignored.
  task automatic run(logic [4:0] op, logic [31:0] od,
    logic [7:0] fl, io, logic [15:0] pc, logic nx, pk);
    host_u.write(`CBSU_OFF_OPND, od, resp);
    host_u.write(`CBSU_OFF_FLAGS, {24'h0, fl}, resp);
    host_u.write(`CBSU_OFF_PC, {16'h0, pc}, resp);
    host_u.write(`CBSU_OFF_IOVAL, {24'h0, io}, resp);
    host_u.write(`CBSU_OFF_NEXTW, {31'h0, nx}, resp);
    host_u.write(`CBSU_OFF_OP, {27'h0, op}, resp);
    if (pk) host_u.write(`CBSU_OFF_PC, 32'h5555, resp);
    res = 32'h0001_0000;
    while (res[16] === 1'b1) host_u.read(`CBSU_OFF_RESULT, res, resp);
    host_u.read(`CBSU_OFF_FLAGS, fw, resp);
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    int p, o, t, n;
    logic [7:0] v, a, fp [3];
    logic [6:0] kp [3];
    logic [7:0] ca [5], cb [5];
    logic [4:0] co [5];
    logic tk;
    logic [2:0] ce;
    logic [15:0] pe;
    fp = '{8'h00, 8'h67, 8'h08};
    kp = '{7'h7d, 7'h3f, 7'h40};
    ca = '{8'h10, 8'h00, 8'h80, 8'h05, 8'h00};
    cb = '{8'h10, 8'h01, 8'h01, 8'h05, 8'hff};
    co = '{5'h00, 5'h02, 5'h00, 5'h01, 5'h01};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    host_u.read(`CBSU_OFF_PC, fw, resp);
    chk(fw, 32'h0, "pc after reset");
    host_u.read(8'h24, fw, resp);
    chk({30'h0, resp}, {30'h0, `CBSU_RESP_SLVERR}, "unmapped read");
    host_u.write(8'h20, 32'h1, resp);
    chk({30'h0, resp}, {30'h0, `CBSU_RESP_SLVERR}, "unmapped write");
    $display("test reset and map done");
    for (n = 0; n < 5; n++) begin
      tk = co[n] == 5'h01;
      run(co[n], {16'h0, cb[n], ca[n]}, 8'hc0 | tk, 8'h0, 16'h0040, 0, 0);
      chk(fw, {24'h0, 8'hc0 | cmpf(ca[n], cb[n], tk)}, "cmp flags");
      chk(res, rx(3'h1, 0, 0, 16'h0041), "cmp result");
    end
    $display("test compares done");
    for (o = 3; o < 8; o++)
      for (t = 0; t < 2; t++)
        for (n = 0; n < 2; n++) begin
          v = (t == o % 2) ? 8'h08 : 8'hf7;
          if (o == 3) v = t ? 8'h5a : 8'ha5;
          a = (o == 3) ? 8'h5a : (o < 6 ? v : ~v);
          run(o[4:0], {13'h0, 3'h3, v, a}, 8'h3f, o < 6 ? ~v : v,
            16'h0100, n[0], 0);
          pe = 16'h0101 + (t ? 16'h1 + n[15:0] : 16'h0);
          ce = t ? 3'h2 + n[2:0] : 3'h1;
          chk(res, rx(ce, 0, t[0], pe), "skip");
          chk(fw, 32'h3f, "skip flags");
        end
    $display("test skips done");
    for (p = 0; p < 3; p++)
      for (o = 8; o < 26; o++) begin
        tk = bcond(o[4:0], fp[p], o[2:0] ^ p[2:0]);
        run(o[4:0], {1'b0, kp[p], 5'h0, o[2:0] ^ p[2:0], 16'h0},
          fp[p], 8'h0, 16'h0020, 0, 0);
        pe = 16'h0021 + (tk ? {{9{kp[p][6]}}, kp[p]} : 16'h0);
        ce = tk ? 3'h2 : 3'h1;
        chk(res, rx(ce, tk, 0, pe), "branch");
        chk(res & 32'hffff, pe, "branch target");
        chk(fw, {24'h0, fp[p]}, "branch flags");
      end
    $display("test branches done");
    host_u.write(`CBSU_OFF_STACK, 32'h1234, resp);
    run(5'h1a, 32'h0, 8'h00, 8'h0, 16'h0300, 0, 1);
    chk(res, rx(3'h4, 0, 0, 16'h1234), "return");
    chk(fw, 32'h80, "return flags");
    host_u.write(`CBSU_OFF_RESULT, 32'h0, resp);
    host_u.read(`CBSU_OFF_RESULT, res, resp);
    chk({16'h0, res[15:0]}, 32'h1234, "result is read only");
    $display("test return done");
    wrap_up();
  end
endmodule // tb_compare_skip_branch_unit
`default_nettype wire
